// ---- dic_pkg.sv ----
// constants shared by the digital input conditioner
package dic_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N_CHANNELS = 8;
  localparam int CLK_HZ = 100_000_000;
  localparam int SCAN_TIME_MS = 5;
  localparam int SCAN_CYCLES = SCAN_TIME_MS * (CLK_HZ / 1000);

  // voltage in millivolts, 0 to 275000
  localparam int VOLT_W = 19;
  localparam logic [VOLT_W-1:0] VOLT_MAX_MV = 19'h43238;
  // thresholds in 0.1 V steps
  localparam int THR_W = 11;
  localparam logic [THR_W-1:0] PICKUP_MIN = 11'h0a0;
  localparam logic [THR_W-1:0] DROPOUT_MIN = 11'h064;
  localparam logic [THR_W-1:0] THR_MAX = 11'h7d0;
  localparam logic [THR_W-1:0] PICKUP_RESET = 11'h370;
  localparam logic [THR_W-1:0] DROPOUT_RESET = 11'h258;
  localparam logic [7:0] MV_PER_STEP = 8'h64;
  localparam logic [7:0] AC_MV_PER_STEP = 8'h0a;

  // delays in 1 ms steps, 0 to 1800000
  localparam int DLY_W = 21;
  localparam logic [DLY_W-1:0] DLY_MAX_MS = 21'h1b7740;
  localparam logic [DLY_W-1:0] DLY_RESET = 21'h000000;
  localparam int ELAPSED_W = 22;
  localparam logic [ELAPSED_W-1:0] SCAN_STEP_MS = 22'h000005;
  localparam logic [ELAPSED_W-1:0] AC_EXTRA_MS = 22'h00001e;

  localparam logic SENSE_NORMALLY_OPEN = 1'b0;
  localparam logic SENSE_NORMALLY_CLOSED = 1'b1;
  localparam logic AC_DISABLED = 1'b0;
  localparam logic CLEAR_REQUEST = 1'b1;

  localparam int COUNT_W = 32;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h00000000;
endpackage : dic_pkg

// ---- dic_channel.sv ----
// one input channel: hysteresis comparator, polarity and rise/fall filter
module dic_channel (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scan_tick,
  // settings, already range limited
  input wire logic [dic_pkg::VOLT_W-1:0] voltage_mv,
  input wire logic [dic_pkg::THR_W-1:0] pickup_voltage_level,
  input wire logic [dic_pkg::THR_W-1:0] dropout_voltage_level,
  input wire logic input_sense_select,
  input wire logic alternating_supply_option,
  input wire logic [dic_pkg::DLY_W-1:0] rise_filter_time,
  input wire logic [dic_pkg::DLY_W-1:0] fall_filter_time,
  // results
  output logic status,
  output logic rise_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic energized_r;
  logic status_r;
  logic rise_r;
  logic [dic_pkg::ELAPSED_W-1:0] elapsed_r;
  logic [dic_pkg::ELAPSED_W-1:0] elapsed_nxt;
  logic [dic_pkg::ELAPSED_W-1:0] need;
  logic [dic_pkg::VOLT_W-1:0] pick_mv;
  logic [dic_pkg::VOLT_W-1:0] rel_mv;
  logic energized_nxt;
  logic raw;

  always_comb begin
    pick_mv = dic_pkg::VOLT_W'(pickup_voltage_level * dic_pkg::MV_PER_STEP);
    if (alternating_supply_option != dic_pkg::AC_DISABLED) begin
      rel_mv = dic_pkg::VOLT_W'(pickup_voltage_level * dic_pkg::AC_MV_PER_STEP); // [R12]
    end else begin
      rel_mv = dic_pkg::VOLT_W'(dropout_voltage_level * dic_pkg::MV_PER_STEP);
    end
    if (voltage_mv > pick_mv) begin
      energized_nxt = 1'b1; // [R6]
    end else if (voltage_mv < rel_mv) begin
      energized_nxt = 1'b0; // [R6]
    end else begin
      energized_nxt = energized_r; // [R16]
    end
  end

  // polarity flips the energized level into the raw status
  assign raw = energized_nxt ^ (input_sense_select == dic_pkg::SENSE_NORMALLY_CLOSED); // [R7] [R8]

  always_comb begin
    if (status_r) begin
      need = dic_pkg::ELAPSED_W'(fall_filter_time); // [R10]
      if (alternating_supply_option != dic_pkg::AC_DISABLED) begin
        need = need + dic_pkg::AC_EXTRA_MS; // [R11]
      end
    end else begin
      need = dic_pkg::ELAPSED_W'(rise_filter_time); // [R9]
    end
    elapsed_nxt = elapsed_r + dic_pkg::SCAN_STEP_MS;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      energized_r <= 1'b0;
    end else if (scan_tick) begin
      energized_r <= energized_nxt; // [R2]
    end
  end

  // a change must persist for whole scans; the scan that reaches the delay flips status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= 1'b0;
      elapsed_r <= '0;
      rise_r <= 1'b0;
    end else begin
      rise_r <= 1'b0;
      if (scan_tick) begin
        if (raw == status_r) begin
          elapsed_r <= '0;
        end else if (elapsed_nxt > need || need == '0 || elapsed_nxt == need) begin
          status_r <= raw; // [R9] [R10]
          rise_r <= raw;
          elapsed_r <= '0;
        end else begin
          elapsed_r <= elapsed_nxt;
        end
      end
    end
  end

  assign status = status_r;
  assign rise_pulse = rise_r;
endmodule : dic_channel

// ---- dic_conditioner.sv ----
// eight-channel digital input conditioner: scan timer, settings, counters, readout
// Functional notes
// R1 - eight independent channels, each with own settings, state, counter, voltage
// R2 - every channel is sampled and updated once per 5 ms scan
// R3 - each channel has its own activation threshold
// R4 - activation threshold 16.0 to 200.0 V in 0.1 V, default 88 V
// R5 - release threshold 10.0 to 200.0 V in 0.1 V, default 60 V
// R6 - normally open: above activation sets, below release clears
// R7 - normally closed: above activation clears, below release sets
// R8 - polarity 0 normally open, 1 normally closed, default open
// R9 - rise delay 0 to 1800 s in 1 ms before status goes 1
// R10 - fall delay, same range, before status goes 0
// R11 - ac mode adds 30 ms to the fall delay, default off
// R12 - ac mode release level is ten percent of activation level
// R13 - 32-bit count of status rises per channel, reset zero
// R14 - clear value 1 zeroes the counter, 0 does nothing
// R15 - per-channel voltage readout 0 to 275 V in 1 mV
// R16 - between the two levels the previous raw state is held
// R17 - clear setting returns to 0 by itself once performed
module dic_conditioner #(
  parameter int SCAN_CYCLES = dic_pkg::SCAN_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // measured voltage from the isolated front ends, millivolts
  input wire logic [dic_pkg::VOLT_W-1:0] channel_voltage_in [dic_pkg::N_CHANNELS],
  // per-channel settings
  input wire logic [dic_pkg::N_CHANNELS-1:0] input_sense_select,
  input wire logic [dic_pkg::N_CHANNELS-1:0] alternating_supply_option,
  input wire logic [dic_pkg::THR_W-1:0] pickup_voltage_level [dic_pkg::N_CHANNELS],
  input wire logic [dic_pkg::THR_W-1:0] dropout_voltage_level [dic_pkg::N_CHANNELS],
  input wire logic [dic_pkg::DLY_W-1:0] rise_filter_time [dic_pkg::N_CHANNELS],
  input wire logic [dic_pkg::DLY_W-1:0] fall_filter_time [dic_pkg::N_CHANNELS],
  input wire logic settings_load,
  // counter clear command: strobe with value
  input wire logic [dic_pkg::N_CHANNELS-1:0] rise_event_count_clear_wr,
  input wire logic [dic_pkg::N_CHANNELS-1:0] rise_event_count_clear_val,
  // results
  output logic [dic_pkg::N_CHANNELS-1:0] input_channel_n,
  output logic [dic_pkg::N_CHANNELS-1:0] rise_event_count_clear,
  output logic [dic_pkg::COUNT_W-1:0] rise_event_count [dic_pkg::N_CHANNELS],
  output logic [dic_pkg::VOLT_W-1:0] channel_voltage_reading [dic_pkg::N_CHANNELS],
  output logic scan_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [18:0] scan_cnt_r;
  logic scan_tick_r;
  logic [dic_pkg::VOLT_W-1:0] volt_meta_r [dic_pkg::N_CHANNELS];
  logic [dic_pkg::VOLT_W-1:0] volt_sync_r [dic_pkg::N_CHANNELS];
  logic [dic_pkg::VOLT_W-1:0] volt_r [dic_pkg::N_CHANNELS];
  logic [dic_pkg::THR_W-1:0] pick_r [dic_pkg::N_CHANNELS];
  logic [dic_pkg::THR_W-1:0] drop_r [dic_pkg::N_CHANNELS];
  logic [dic_pkg::DLY_W-1:0] rise_r [dic_pkg::N_CHANNELS];
  logic [dic_pkg::DLY_W-1:0] fall_r [dic_pkg::N_CHANNELS];
  logic [dic_pkg::N_CHANNELS-1:0] sense_r;
  logic [dic_pkg::N_CHANNELS-1:0] ac_r;
  logic [dic_pkg::N_CHANNELS-1:0] clear_pend_r;
  logic [dic_pkg::N_CHANNELS-1:0] rise_pulse;
  logic [dic_pkg::COUNT_W-1:0] count_r [dic_pkg::N_CHANNELS];

  // scan timer: one-cycle enable every scan period
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scan_cnt_r <= '0;
      scan_tick_r <= 1'b0;
    end else if (scan_cnt_r == 19'(SCAN_CYCLES - 1)) begin
      scan_cnt_r <= '0;
      scan_tick_r <= 1'b1; // [R2]
    end else begin
      scan_cnt_r <= scan_cnt_r + 19'h00001;
      scan_tick_r <= 1'b0;
    end
  end

  assign scan_strobe = scan_tick_r;

  genvar g;
  generate
    for (g = 0; g < dic_pkg::N_CHANNELS; g++) begin : gen_ch
      // front-end word crosses in through two flops; only read once per scan,
      // long after it settled, which limits the multi-bit hazard
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          volt_meta_r[g] <= '0;
          volt_sync_r[g] <= '0;
        end else begin
          volt_meta_r[g] <= channel_voltage_in[g];
          volt_sync_r[g] <= volt_meta_r[g];
        end
      end

      // readout sampled at the scan and limited to the measuring span
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          volt_r[g] <= '0;
        end else if (scan_tick_r) begin
          if (volt_sync_r[g] > dic_pkg::VOLT_MAX_MV) begin
            volt_r[g] <= dic_pkg::VOLT_MAX_MV; // [R15]
          end else begin
            volt_r[g] <= volt_sync_r[g]; // [R15]
          end
        end
      end

      // settings held per channel, clamped into their documented spans
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          pick_r[g] <= dic_pkg::PICKUP_RESET; // [R4]
          drop_r[g] <= dic_pkg::DROPOUT_RESET; // [R5]
          rise_r[g] <= dic_pkg::DLY_RESET;
          fall_r[g] <= dic_pkg::DLY_RESET;
          sense_r[g] <= dic_pkg::SENSE_NORMALLY_OPEN; // [R8]
          ac_r[g] <= dic_pkg::AC_DISABLED; // [R11]
        end else if (settings_load) begin
          if (pickup_voltage_level[g] < dic_pkg::PICKUP_MIN) begin
            pick_r[g] <= dic_pkg::PICKUP_MIN; // [R3] [R4]
          end else if (pickup_voltage_level[g] > dic_pkg::THR_MAX) begin
            pick_r[g] <= dic_pkg::THR_MAX;
          end else begin
            pick_r[g] <= pickup_voltage_level[g]; // [R3]
          end
          if (dropout_voltage_level[g] < dic_pkg::DROPOUT_MIN) begin
            drop_r[g] <= dic_pkg::DROPOUT_MIN; // [R5]
          end else if (dropout_voltage_level[g] > dic_pkg::THR_MAX) begin
            drop_r[g] <= dic_pkg::THR_MAX;
          end else begin
            drop_r[g] <= dropout_voltage_level[g];
          end
          if (rise_filter_time[g] > dic_pkg::DLY_MAX_MS) begin
            rise_r[g] <= dic_pkg::DLY_MAX_MS; // [R9]
          end else begin
            rise_r[g] <= rise_filter_time[g];
          end
          if (fall_filter_time[g] > dic_pkg::DLY_MAX_MS) begin
            fall_r[g] <= dic_pkg::DLY_MAX_MS; // [R10]
          end else begin
            fall_r[g] <= fall_filter_time[g];
          end
          sense_r[g] <= input_sense_select[g];
          ac_r[g] <= alternating_supply_option[g];
        end
      end

      dic_channel u_channel (
        .clk(clk),
        .rst_b(rst_b),
        .scan_tick(scan_tick_r),
        .voltage_mv(volt_r[g]),
        .pickup_voltage_level(pick_r[g]),
        .dropout_voltage_level(drop_r[g]),
        .input_sense_select(sense_r[g]),
        .alternating_supply_option(ac_r[g]),
        .rise_filter_time(rise_r[g]),
        .fall_filter_time(fall_r[g]),
        .status(input_channel_n[g]), // [R1]
        .rise_pulse(rise_pulse[g])
      );

      // clear setting reads 1 until performed, then falls back to 0 by itself
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          clear_pend_r[g] <= 1'b0;
        end else if (rise_event_count_clear_wr[g]) begin
          clear_pend_r[g] <= (rise_event_count_clear_val[g] == dic_pkg::CLEAR_REQUEST); // [R14]
        end else begin
          clear_pend_r[g] <= 1'b0; // [R17]
        end
      end

      // a rise landing on the clearing cycle is kept as a count of one
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          count_r[g] <= dic_pkg::COUNT_RESET; // [R13]
        end else if (clear_pend_r[g]) begin
          count_r[g] <= {{(dic_pkg::COUNT_W-1){1'b0}}, rise_pulse[g]}; // [R14]
        end else if (rise_pulse[g]) begin
          count_r[g] <= count_r[g] + 32'h00000001; // [R13]
        end
      end

      assign rise_event_count[g] = count_r[g];
      assign channel_voltage_reading[g] = volt_r[g];
    end
  endgenerate

  assign rise_event_count_clear = clear_pend_r;
endmodule : dic_conditioner

// ---- dic_front_end.sv ----
// behavioural isolated front end giving each channel's voltage in millivolts
module dic_front_end (
  // clock
  input wire logic clk,
  // wanted and delivered voltage
  input wire logic [dic_pkg::VOLT_W-1:0] target_mv [dic_pkg::N_CHANNELS],
  output logic [dic_pkg::VOLT_W-1:0] channel_voltage_in [dic_pkg::N_CHANNELS]
);
  timeunit 1ns;
  timeprecision 1ps;
  // channels are isolated, each follows only its own source
  always_ff @(posedge clk) begin
    channel_voltage_in <= target_mv;
  end
endmodule : dic_front_end

// ---- dic_conditioner_assertions.sv ----
// port checker for the input conditioner
module dic_conditioner_assertions (
  // clock, reset, clear command
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [dic_pkg::N_CHANNELS-1:0] rise_event_count_clear_wr,
  input wire logic [dic_pkg::N_CHANNELS-1:0] rise_event_count_clear_val,
  // results
  input wire logic [dic_pkg::N_CHANNELS-1:0] input_channel_n,
  input wire logic [dic_pkg::N_CHANNELS-1:0] rise_event_count_clear,
  input wire logic [dic_pkg::COUNT_W-1:0] rise_event_count [dic_pkg::N_CHANNELS],
  input wire logic [dic_pkg::VOLT_W-1:0] channel_voltage_reading [dic_pkg::N_CHANNELS],
  input wire logic scan_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_strobe_pulse: assert property (scan_strobe |=> !scan_strobe [*8]) else $error("strobe");
  chk_status_scan: assert property (!$stable(input_channel_n) |-> $past(scan_strobe)) else $error("status");
  chk_clear_echo: assert property (
    rise_event_count_clear == $past(rise_event_count_clear_wr & rise_event_count_clear_val)) else $error("echo");
  for (genvar i = 0; i < dic_pkg::N_CHANNELS; i++) begin : g_ch
    chk_read_scan: assert property (
      !$stable(channel_voltage_reading[i]) |-> $past(scan_strobe)) else $error("reading");
    chk_read_max: assert property (channel_voltage_reading[i] <= dic_pkg::VOLT_MAX_MV) else $error("max");
    chk_clear_zero: assert property (
      rise_event_count_clear[i] |=> rise_event_count[i] <= 32'h1) else $error("clear");
    chk_count_up: assert property (
      $rose(input_channel_n[i]) && !rise_event_count_clear[i] |=>
      rise_event_count[i] == $past(rise_event_count[i]) + 32'h1) else $error("rise");
    chk_count_hold: assert property (
      !$rose(input_channel_n[i]) && !rise_event_count_clear[i] |=> $stable(rise_event_count[i])) else $error("hold");
  end
  cover property ($rose(input_channel_n[0]));
  cover property ($fell(input_channel_n[0]));
  cover property (|rise_event_count_clear);
endmodule : dic_conditioner_assertions
bind dic_conditioner dic_conditioner_assertions u_chk (.clk, .rst_b, .rise_event_count_clear_wr,
  .rise_event_count_clear_val, .input_channel_n, .rise_event_count_clear, .rise_event_count,
  .channel_voltage_reading, .scan_strobe);

// ---- dic_conditioner_bench.sv ----
// self-checking bench for the input conditioner
module dic_conditioner_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = dic_pkg::N_CHANNELS;
  localparam int VW = dic_pkg::VOLT_W;
  logic clk = 1'b0, rst_b = 1'b0, ld = 1'b0, stb;
  logic [VW-1:0] tgt [N], vin [N], rd [N];
  logic [10:0] pk [N], dp [N];
  logic [20:0] rt [N], ft [N];
  logic [31:0] cnt [N], ecnt [N] = '{default: 32'h0};
  int mp [N] = '{default: 32'h370};
  int md [N] = '{default: 32'h258};
  logic [7:0] se = 8'hff, ac = 8'h00, cwr = 8'h00, cval = 8'h00;
  logic [7:0] ms = 8'h00, ma = 8'h00, een = 8'h00, est = 8'h00, st, clr;
  int seed = 32'h5a142bdb;
  int fail_count = 0, checks = 0, cyc = 0;
  int steps [6] = '{32'h157c0, 32'h157c1, 32'hea60, 32'hea5f, 32'h157c1, 32'h7ffff};
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  dic_front_end u_fe (.clk, .target_mv(tgt), .channel_voltage_in(vin));
  dic_conditioner #(.SCAN_CYCLES(50)) u_dut (.clk, .rst_b, .channel_voltage_in(vin), .input_sense_select(se),
    .alternating_supply_option(ac), .pickup_voltage_level(pk), .dropout_voltage_level(dp),
    .rise_filter_time(rt), .fall_filter_time(ft), .settings_load(ld), .rise_event_count_clear_wr(cwr),
    .rise_event_count_clear_val(cval), .input_channel_n(st), .rise_event_count_clear(clr),
    .rise_event_count(cnt), .channel_voltage_reading(rd), .scan_strobe(stb));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // readout expectation: the measuring span ends at the package maximum
  function automatic logic [31:0] exp_reading(input logic [VW-1:0] v);
    return v > dic_pkg::VOLT_MAX_MV ? 32'(dic_pkg::VOLT_MAX_MV) : 32'(v);
  endfunction : exp_reading
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // status lands one cycle after the strobe, so look just past the edge ending it
  task automatic scans(input int n);
    repeat (n) @(posedge clk iff stb === 1'b1);
    #1;
  endtask : scans
  task automatic load_all();
    ld = 1'b1;
    ms = se;
    ma = ac;
    foreach (mp[i]) begin
      mp[i] = pk[i];
      md[i] = dp[i];
    end
    @(posedge clk);
    #1 ld = 1'b0;
  endtask : load_all
  // hysteresis model; eight scans cover the 30 ms ac tail
  task automatic round();
    int rel;
    for (int i = 0; i < N; i++) begin
      rel = ma[i] ? mp[i] * dic_pkg::AC_MV_PER_STEP : md[i] * dic_pkg::MV_PER_STEP;
      if (tgt[i] > mp[i] * dic_pkg::MV_PER_STEP) een[i] = 1'b1;
      else if (tgt[i] < rel) een[i] = 1'b0;
      if ((een[i] ^ ms[i]) && !est[i]) ecnt[i]++;
      est[i] = een[i] ^ ms[i];
    end
    scans(8);
    check("status", 32'(st), 32'(est));
    for (int i = 0; i < N; i++) begin
      check("count", cnt[i], ecnt[i]);
      check("reading", 32'(rd[i]), exp_reading(tgt[i]));
    end
  endtask : round
  task automatic dly(input logic [VW-1:0] v, input int n, input logic [7:0] e);
    foreach (tgt[i]) tgt[i] = v;
    scans(n);
    check("filtered", 32'(st), 32'(e));
  endtask : dly
  task automatic clear(input logic [7:0] w, input logic [7:0] v);
    cwr = w;
    cval = v;
    @(posedge clk);
    #1 cwr = 8'h00;
    check("clear echo", 32'(clr), 32'(w & v));
    foreach (ecnt[i]) if (w[i] && v[i]) ecnt[i] = 32'h0;
    @(posedge clk);
    #1 check("clear back", 32'(clr), 32'h0);
  endtask : clear
  initial begin
    foreach (tgt[i]) begin
      tgt[i] = '0;
      pk[i] = 11'h7d0;
      dp[i] = 11'h7d0;
      rt[i] = 21'h14;
      ft[i] = 21'h0f;
    end
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    check("reset count", cnt[7], 32'h0);
    // nothing loaded yet, so the reset settings are in force
    foreach (steps[k]) begin
      foreach (tgt[i]) tgt[i] = VW'(steps[k]);
      round();
    end
    foreach (pk[i]) begin
      pk[i] = 11'h370;
      dp[i] = 11'h258;
    end
    se = 8'h00;
    load_all();
    dly('0, 3, 8'hff);
    dly('0, 2, 8'h00);
    dly(19'h186a0, 3, 8'h00);
    dly(19'h186a0, 3, 8'hff);
    ac = 8'hff;
    foreach (ft[i]) ft[i] = '0;
    load_all();
    dly('0, 4, 8'hff);
    dly('0, 5, 8'h00);
    ac = 8'h00;
    foreach (rt[i]) rt[i] = '0;
    een = 8'h00;
    est = 8'h00;
    clear(8'hff, 8'hff);
    for (int r = 0; r < 12; r++) begin
      if (r % 4 == 0) begin
        foreach (pk[i]) begin
          pk[i] = 11'(dic_pkg::PICKUP_MIN + {$random(seed)} % (dic_pkg::THR_MAX - dic_pkg::PICKUP_MIN + 1));
          dp[i] = 11'(dic_pkg::DROPOUT_MIN + {$random(seed)} % (dic_pkg::THR_MAX - dic_pkg::DROPOUT_MIN + 1));
        end
        se = 8'($random(seed));
        ac = 8'($random(seed));
        load_all();
        // new settings meet the old voltage first, so let that settle
        round();
      end
      foreach (tgt[i]) tgt[i] = VW'({$random(seed)} % 32'h38270);
      round();
      clear(8'($random(seed)), 8'($random(seed)));
    end
    // a reset in mid-run must zero the counters and bring back every default
    rst_b = 1'b0;
    @(posedge clk);
    #1 rst_b = 1'b1;
    foreach (cnt[i]) check("reset count", cnt[i], 32'h0);
    check("reset status", 32'(st), 32'h0);
    ms = 8'h00;
    ma = 8'h00;
    een = 8'h00;
    est = 8'h00;
    foreach (mp[i]) begin
      mp[i] = dic_pkg::PICKUP_RESET;
      md[i] = dic_pkg::DROPOUT_RESET;
      ecnt[i] = 32'h0;
    end
    foreach (tgt[i]) tgt[i] = VW'(steps[1]);
    round();
    conclude();
  end
endmodule : dic_conditioner_bench
